// File: hdl/padc_output_port.sv
// Digital back end of a 12-bit pipelined sampling converter
//
// What this block does
// - Parallel 12-bit word, top bit is MSB.
// - Disable pin high floats all data outputs.
// - Invert select high flips the top bit.
// - Valid data 6.5 convert cycles after start.
// - Offset binary: full scale gives all ones.
// - Two's complement differs only in top bit.
// - Mid-scale gives 100..0, negative full scale zeros.
// - Eleven two-bit stages on double-rate sub-clock.
// - Delay lines align stages, redundancy corrects codes.
// - Non-overlapping track and hold phases drive switches.
`timescale 1ns/1ns
`default_nettype none
module padc_output_port (
    input wire logic clk,                                  // System clock, 250 MHz
    input wire logic reset,                                // Synchronous reset, active high
    input wire logic convert_clk,                          // External convert clock pin
    input wire logic output_disable,                       // High floats the data outputs
    input wire logic top_bit_invert_select,                // High gives two's complement coding
    input wire logic [padc_pkg::RAW_W-1:0] stage_code,     // Raw two-bit codes, stage 0 in low bits
    output logic [padc_pkg::DATA_W-1:0] sample_word,       // Bit 11 sample_bit_top, bit 0 sample_bit_bottom
    output logic [padc_pkg::DATA_W-1:0] sample_word_oe_n,  // Low while a data line is driven
    output logic track_phase,                              // Track switch phase, samples input
    output logic hold_phase,                               // Hold switch phase, redistributes charge
    output logic twos_complement_coding,                   // Coding now applied to the word
    output logic data_valid                                // Pipeline filled, word is a real sample
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic conv_sync;
    logic disable_sync;
    logic invert_sync;
    logic [padc_pkg::RAW_W-1:0] code_sync;

    padc_sync #(.W(1)) u_sync_clk (
        .clk(clk),
        .reset(reset),
        .din(convert_clk),
        .dout(conv_sync)
    );

    padc_sync #(.W(1)) u_sync_disable (
        .clk(clk),
        .reset(reset),
        .din(output_disable),
        .dout(disable_sync)
    );

    padc_sync #(.W(1)) u_sync_invert (
        .clk(clk),
        .reset(reset),
        .din(top_bit_invert_select),
        .dout(invert_sync)
    );

    // Codes pass the same two stages as the clock, so edges and codes stay paired
    padc_sync #(.W(padc_pkg::RAW_W)) u_sync_code (
        .clk(clk),
        .reset(reset),
        .din(stage_code),
        .dout(code_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sub-clock edge detection

    logic conv_prev;
    logic [padc_pkg::RAW_W-1:0] code_prev;
    logic rise_edge;
    logic fall_edge;
    logic sub_edge;

    // At an edge event code_prev still holds the previous edge's codes, which have
    // been still for half a cycle; each stage code is therefore taken one edge late
    always_ff @(posedge clk) begin
        if (reset) begin
            conv_prev <= 1'b0;
            code_prev <= padc_pkg::RAW_RESET;
        end else begin
            conv_prev <= conv_sync;
            code_prev <= code_sync;
        end
    end

    // Both convert clock edges advance the pipeline, giving a double-rate sub-clock
    assign rise_edge = conv_sync & ~conv_prev;
    assign fall_edge = ~conv_sync & conv_prev;
    assign sub_edge = rise_edge | fall_edge;

    ////////////////////////////////////////////////////////////////////////////
    // Track and hold phase generation

    logic [3:0] gap_count;
    logic next_track;
    logic next_hold;

    always_ff @(posedge clk) begin
        if (reset) begin
            gap_count <= padc_pkg::GAP_ZERO;
        end else if (sub_edge) begin
            gap_count <= padc_pkg::PHASE_GAP_CYC;
        end else if (gap_count != padc_pkg::GAP_ZERO) begin
            gap_count <= gap_count - padc_pkg::COUNT_ONE;
        end
    end

    // Both phases stay low during the gap so the switches never overlap
    always_comb begin
        next_track = 1'b0;
        next_hold = 1'b0;
        if (gap_count == padc_pkg::GAP_ZERO && !sub_edge) begin
            next_track = conv_prev;
            next_hold = ~conv_prev;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            track_phase <= 1'b0;
            hold_phase <= 1'b0;
        end else begin
            track_phase <= next_track;
            hold_phase <= next_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage delay lines

    // Stage k resolves k+1 sub-edges after the sample and waits 10-k more edges
    logic [padc_pkg::STAGE_BITS-1:0] aligned [padc_pkg::STAGES];

    genvar gk;
    generate
        for (gk = 0; gk < padc_pkg::LAST_STAGE; gk++) begin : g_stage
            padc_delay_line #(.DEPTH(padc_pkg::LAST_STAGE - gk)) u_delay (
                .clk(clk),
                .reset(reset),
                .shift(sub_edge),
                .din(code_prev[gk*padc_pkg::STAGE_BITS +: padc_pkg::STAGE_BITS]),
                .dout(aligned[gk])
            );
        end
    endgenerate

    // The last stage is already aligned when it resolves
    assign aligned[padc_pkg::LAST_STAGE] =
        code_prev[padc_pkg::LAST_STAGE*padc_pkg::STAGE_BITS +: padc_pkg::STAGE_BITS];

    ////////////////////////////////////////////////////////////////////////////
    // Digital error correction

    // Each stage carries one redundant bit; weights overlap by one position
    function automatic logic [13:0] padc_weight(input logic [1:0] code, input int shift_by);
        logic [13:0] wide;
        wide = {12'h000, code};
        return 14'(wide << shift_by);
    endfunction

    logic [13:0] corr_sum;
    logic [padc_pkg::DATA_W-1:0] corrected;

    always_comb begin
        corr_sum = 14'h0000;
        for (int k = 0; k < padc_pkg::STAGES; k++) begin
            corr_sum = corr_sum + padc_weight(aligned[k], padc_pkg::LAST_STAGE - k);
        end
    end

    // Overrange saturates at full scale so codes never roll over
    always_comb begin
        if (corr_sum > padc_pkg::FULL_SCALE_WIDE) begin
            corrected = padc_pkg::FULL_SCALE;
        end else begin
            corrected = corr_sum[padc_pkg::DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Aligned word hold and output register

    logic [padc_pkg::DATA_W-1:0] held_word;
    logic [padc_pkg::DATA_W-1:0] next_word;
    logic align_take;
    logic word_update;

    // All stages of a sample are in once falling edge 11 has shifted; the delay
    // lines settle a clock later, so the word is taken at the next rising edge,
    // 12 sub-edges after the sample, while its codes are stable
    assign align_take = rise_edge;

    // The output moves only on falling edges, one convert cycle apart
    assign word_update = fall_edge;

    always_ff @(posedge clk) begin
        if (reset) begin
            held_word <= padc_pkg::WORD_RESET;
        end else if (align_take) begin
            held_word <= corrected;
        end
    end

    // Two's complement is offset binary with the top bit flipped
    always_comb begin
        next_word = held_word;
        next_word[padc_pkg::TOP_BIT] = held_word[padc_pkg::TOP_BIT] ^ invert_sync;
    end

    // One update per convert cycle, on the falling edge, 13 sub-edges after the sample
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_word <= padc_pkg::WORD_RESET;
        end else if (word_update) begin
            sample_word <= next_word;
        end
    end

    // Coding flag follows the select as it stood at the last word update
    always_ff @(posedge clk) begin
        if (reset) begin
            twos_complement_coding <= 1'b0;
        end else if (word_update) begin
            twos_complement_coding <= invert_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output enables

    // The disable pin is taken as static; it still reacts at any time
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_word_oe_n <= padc_pkg::WORD_RESET;
        end else begin
            sample_word_oe_n <= {padc_pkg::DATA_W{disable_sync}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pipeline fill tracking

    // The first real word shows on falling edge 13; valid rises one fall later
    // and then stays high, so it marks only a fully filled pipeline
    padc_pkg::padc_fill_e fill_state;
    padc_pkg::padc_fill_e next_fill_state;
    logic [3:0] fill_count;

    always_comb begin
        next_fill_state = fill_state;
        case (fill_state)
            padc_pkg::PADC_WAIT: begin
                if (rise_edge) begin
                    next_fill_state = padc_pkg::PADC_FILL;
                end
            end
            padc_pkg::PADC_FILL: begin
                if (fall_edge && fill_count == padc_pkg::FILL_SAMPLES) begin
                    next_fill_state = padc_pkg::PADC_RUN;
                end
            end
            padc_pkg::PADC_RUN: begin
                next_fill_state = padc_pkg::PADC_RUN;
            end
            default: begin
                next_fill_state = padc_pkg::PADC_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fill_state <= padc_pkg::PADC_WAIT;
        end else begin
            fill_state <= next_fill_state;
        end
    end

    // Counts falling edges since the first sample start
    always_ff @(posedge clk) begin
        if (reset) begin
            fill_count <= padc_pkg::GAP_ZERO;
        end else if (fill_state == padc_pkg::PADC_FILL && fall_edge) begin
            fill_count <= fill_count + padc_pkg::COUNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_valid <= 1'b0;
        end else begin
            data_valid <= (next_fill_state == padc_pkg::PADC_RUN);
        end
    end

endmodule
`default_nettype wire

// File: hdl/padc_pkg.sv
// Constants shared by the pipelined converter output port
package padc_pkg;

    // Output word layout
    localparam int DATA_W = 12;
    localparam int TOP_BIT = 11;
    localparam int BOTTOM_BIT = 0;

    // Quantizer pipeline structure
    localparam int STAGES = 11;
    localparam int STAGE_BITS = 2;
    localparam int RAW_W = 22;
    localparam int LAST_STAGE = 10;

    // Sub-clock edges from sample start to aligned data and to the output
    localparam int ALIGN_HALF = 11;
    localparam int LATENCY_HALF = 13;

    // Reset values and code limits
    localparam logic [DATA_W-1:0] WORD_RESET = 12'h000;
    localparam logic [DATA_W-1:0] FULL_SCALE = 12'hFFF;
    localparam logic [13:0] FULL_SCALE_WIDE = 14'h0FFF;
    localparam logic [RAW_W-1:0] RAW_RESET = 22'h000000;

    // Output shows valid data after this many whole convert cycles
    localparam logic [3:0] FILL_SAMPLES = 4'h7;

    // Non-overlap gap between track and hold phases
    localparam int CLK_PERIOD_NS = 4;
    localparam int PHASE_GAP_NS = 4;
    localparam int PHASE_GAP_CYC_I = (PHASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PHASE_GAP_CYC = PHASE_GAP_CYC_I[3:0];
    localparam logic [3:0] GAP_ZERO = 4'h0;
    localparam logic [3:0] COUNT_ONE = 4'h1;

    // Fill tracking states
    typedef enum logic [1:0] {
        PADC_WAIT = 2'b00,
        PADC_FILL = 2'b01,
        PADC_RUN = 2'b10
    } padc_fill_e;

endpackage

// File: hdl/padc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module padc_sync #(
    parameter int W = 1
) (
    input wire logic clk,          // System clock
    input wire logic reset,        // Synchronous reset, active high
    input wire logic [W-1:0] din,  // Asynchronous pin level
    output logic [W-1:0] dout      // Synchronised level
);

    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule
`default_nettype wire

// File: hdl/padc_delay_line.sv
// Per-stage delay line that time-aligns a stage code to the last stage
`timescale 1ns/1ns
`default_nettype none
module padc_delay_line #(
    parameter int DEPTH = 1
) (
    input wire logic clk,          // System clock
    input wire logic reset,        // Synchronous reset, active high
    input wire logic shift,        // One pulse per sub-clock edge
    input wire logic [1:0] din,    // Stage code captured at this edge
    output logic [1:0] dout        // Code delayed by DEPTH edges
);

    logic [1:0] taps [DEPTH];

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                taps[i] <= 2'h0;
            end
        end else if (shift) begin
            taps[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                taps[i] <= taps[i-1];
            end
        end
    end

    assign dout = taps[DEPTH-1];

endmodule
`default_nettype wire

// File: hdl/padc_output_port_fix.sv
// Spare design source; holds no logic

// File: bench/padc_output_port_monitor.sv
// Assertion checker for the converter output port
`timescale 1ns/1ns
`default_nettype none
module padc_output_port_monitor (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic convert_clk, // Convert pin
    input wire logic output_disable, // Disable pin
    input wire logic top_bit_invert_select, // Invert pin
    input wire logic [padc_pkg::RAW_W-1:0] stage_code, // Stage codes
    input wire logic [padc_pkg::DATA_W-1:0] sample_word, // Word
    input wire logic [padc_pkg::DATA_W-1:0] sample_word_oe_n, // Enables
    input wire logic track_phase, // Track
    input wire logic hold_phase, // Hold
    input wire logic twos_complement_coding, // Coding
    input wire logic data_valid // Valid
);
    logic ck_d;
    logic [3:0] age;
    ////////////////////////////////////////////////////////////////
    // Clocks since the last falling convert edge, saturating
    always_ff @(posedge clk) begin
        ck_d <= convert_clk;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            age <= 4'hF;
        end else if (ck_d && !convert_clk) begin
            age <= 4'h0;
        end else if (age != 4'hF) begin
            age <= age + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_excl;
        !(track_phase && hold_phase);
    endproperty
    a_excl: assert property (p_excl) else $error("phases overlap");
    property p_gap_track;
        $rose(track_phase) |-> !$past(hold_phase);
    endproperty
    a_gap_track: assert property (p_gap_track) else $error("no gap before track");
    property p_gap_hold;
        $rose(hold_phase) |-> !$past(track_phase);
    endproperty
    a_gap_hold: assert property (p_gap_hold) else $error("no gap before hold");
    property p_track_on;
        $rose(convert_clk) |-> ##[2:5] track_phase;
    endproperty
    a_track_on: assert property (p_track_on) else $error("track late");
    property p_oe_eq;
        sample_word_oe_n == 12'h000 || sample_word_oe_n == 12'hFFF;
    endproperty
    a_oe_eq: assert property (p_oe_eq) else $error("enables differ");
    property p_oe_off;
        $rose(output_disable) |-> ##[1:4] sample_word_oe_n == 12'hFFF;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("outputs not floated");
    property p_word_time;
        $changed(sample_word) |-> age inside {[4'h1:4'h5]};
    endproperty
    a_word_time: assert property (p_word_time) else $error("word moved off update");
    property p_tc_time;
        $changed(twos_complement_coding) |-> age inside {[4'h1:4'h5]};
    endproperty
    a_tc_time: assert property (p_tc_time) else $error("coding moved off update");
    property p_valid_hold;
        data_valid |=> data_valid;
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");
endmodule
bind padc_output_port padc_output_port_monitor u_mon (.clk(clk), .reset(reset), .convert_clk(convert_clk),
    .output_disable(output_disable), .top_bit_invert_select(top_bit_invert_select), .stage_code(stage_code),
    .sample_word(sample_word), .sample_word_oe_n(sample_word_oe_n), .track_phase(track_phase),
    .hold_phase(hold_phase), .twos_complement_coding(twos_complement_coding), .data_valid(data_valid));
`default_nettype wire

// File: bench/padc_capture.sv
// Capture logic that latches the parallel word mid-cycle
`timescale 1ns/1ns
`default_nettype none
module padc_capture (
    input wire logic convert_clk, // Convert clock
    input wire logic [padc_pkg::DATA_W-1:0] sample_word, // Word
    input wire logic [padc_pkg::DATA_W-1:0] sample_word_oe_n, // Enables
    output logic [padc_pkg::DATA_W-1:0] cap_word // Latched word
);
    logic [padc_pkg::DATA_W-1:0] bus_line;
    // A floated bus shows a changing level, not the last word
    assign bus_line = (sample_word_oe_n == 12'h000) ? sample_word : ~cap_word;
    always_ff @(posedge convert_clk) begin
        cap_word <= bus_line;
    end
endmodule
`default_nettype wire

// File: bench/pipelined_adc_output_port_tb.sv
// Self-checking bench for the converter output port
`timescale 1ns/1ns
`default_nettype none
module pipelined_adc_output_port_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic convert_clk = 1'b0;
    logic output_disable = 1'b0;
    logic top_bit_invert_select = 1'b0;
    logic [21:0] stage_code = 22'h000000;
    logic [11:0] sample_word, sample_word_oe_n, cap_word, last_exp;
    logic track_phase, hold_phase, twos_complement_coding, data_valid;
    logic last_ok = 1'b0;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int cyc = 0;
    int edge_n = 0;
    logic [21:0] raw [0:255];
    logic [21:0] pat [0:2] = '{22'h000000, 22'h000002, 22'h3FFFFF};
    always #2 clk = ~clk;
    padc_output_port dut (.clk(clk), .reset(reset), .convert_clk(convert_clk), .output_disable(output_disable),
        .top_bit_invert_select(top_bit_invert_select), .stage_code(stage_code), .sample_word(sample_word),
        .sample_word_oe_n(sample_word_oe_n), .track_phase(track_phase), .hold_phase(hold_phase),
        .twos_complement_coding(twos_complement_coding), .data_valid(data_valid));
    padc_capture partner (.convert_clk(convert_clk), .sample_word(sample_word),
        .sample_word_oe_n(sample_word_oe_n), .cap_word(cap_word));
    ////////////////////////////////////////////////////////////////
    task automatic check_word(input logic [11:0] exp, input logic [11:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic check_flag(input logic exp, input logic got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            results();
        end
    end
    // Weighted sum of stage codes, saturated, top bit flipped when inverted
    function automatic logic [11:0] exp_word(input logic [21:0] r, input logic inv);
        int s;
        s = 0;
        for (int k = 0; k < 11; k++) begin
            s = s + (int'(r[2*k+:2]) << (10 - k));
        end
        if (s > 4095) begin
            s = 4095;
        end
        return 12'(s) ^ {inv, 11'h000};
    endfunction
    // Stage k carries the sample that rose k+1 edges ago, else noise
    function automatic logic [21:0] codes_at(input int e);
        logic [21:0] c;
        c = 22'($urandom);
        for (int k = 0; k < 11; k++) begin
            if (e - k - 1 >= 0 && (e - k - 1) % 2 == 0) begin
                c[2*k+:2] = raw[(e - k - 1) / 2][2*k+:2];
            end
        end
        return c;
    endfunction
    ////////////////////////////////////////////////////////////////
    // One convert cycle of 16 clocks high and 16 low
    task automatic conv_cycle(input int mode, input logic inv, input logic dis);
        logic [11:0] e;
        raw[cyc] = (mode == 3) ? 22'($urandom) : pat[mode];
        convert_clk <= 1'b1;
        top_bit_invert_select <= inv;
        output_disable <= dis;
        stage_code <= codes_at(edge_n);
        edge_n = edge_n + 1;
        repeat (2) @(posedge clk);
        if (last_ok) begin
            check_word(last_exp, cap_word);
        end
        repeat (14) @(posedge clk);
        check_flag(1'b1, track_phase);
        check_flag(1'b0, hold_phase);
        convert_clk <= 1'b0;
        stage_code <= codes_at(edge_n);
        edge_n = edge_n + 1;
        repeat (4) @(posedge clk);
        check_word(dis ? 12'hFFF : 12'h000, sample_word_oe_n);
        e = 12'h000;
        if (cyc >= 6) begin
            e = exp_word(raw[cyc - 6], inv);
            check_word(e, sample_word);
            check_flag(inv, twos_complement_coding);
        end
        check_flag(cyc >= 7, data_valid);
        last_ok = (cyc >= 6) && !dis;
        last_exp = e;
        repeat (12) @(posedge clk);
        check_flag(1'b0, track_phase);
        check_flag(1'b1, hold_phase);
        cyc = cyc + 1;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(91));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        // Modes: negative full scale, bipolar zero, full scale, random
        for (int t = 0; t < 8; t++) begin
            for (int i = 0; i < 12; i++) begin
                conv_cycle(t % 4, t[2], t == 5);
            end
            $display("test %0d done", t);
        end
        results();
    end
endmodule
`default_nettype wire
